// [pkg/mgmt_serial_defs.vh]
/*
 file: constants for the management serial target, frame layout and timing.
 assumes: included by bare name from the design files.
*/
`ifndef MGMT_SERIAL_DEFS_VH
`define MGMT_SERIAL_DEFS_VH

// frame field codes
`define START_CODE      2'b01
`define OP_READ         2'b10
`define OP_WRITE        2'b01
`define TA_WRITE        2'b10
// field widths
`define ADDR_W          5
`define DATA_W          16
`define REG_COUNT       32
// reset value of every register
`define REG_RESET       16'h0000
// bit counts within a frame after start
`define CNT_OPEND       6'd1
`define CNT_PHYEND      6'd6
`define CNT_REGEND      6'd11
`define CNT_TA1         6'd12
`define CNT_TA2         6'd13
`define CNT_DATAEND     6'd29
// clocks without an mdc edge before a frame is dropped (200 clocks)
`define STALL_LIMIT     8'hc8

`endif

// [hdl/reg_store.v]
/*
 file: small register store, 32 words of 16 bits, registered read data.
 assumes: single clock, synchronous active-high reset.
*/
`include "mgmt_serial_defs.vh"

module reg_store (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   // write port
   input  wire        wr_en,
   input  wire [4:0]  wr_addr,
   input  wire [15:0] wr_data,
   // read port
   input  wire [4:0]  rd_addr,
   output reg  [15:0] rd_data
);

   reg [15:0] mem [0:`REG_COUNT-1];
   integer    i;

   // write and registered read
   always @(posedge clk) begin
      if (reset) begin
         for (i = 0; i < `REG_COUNT; i = i + 1) begin
            mem[i] <= `REG_RESET;
         end
         rd_data <= `REG_RESET;
      end else begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end

endmodule // reg_store

// [hdl/mdio_management_target.v]
/*
 file: management serial target, frame decode, address match, turnaround,
       read and write of thirty-two 16-bit registers.
       frame after the start code: opcode 2, bus address 5, register 5,
       turnaround 2, data 16, each field msb first.
       a frame whose mdc stops for STALL_LIMIT clocks is dropped and the
       line let go, so a station that dies mid-read cannot hold mdio.
 assumes: mdc and mdio come from outside and are synchronised here; clk is
          much faster than mdc (125 MHz vs at most 25 MHz); an external
          pull-up resolves mdio when mdio_oe is low.
          each mdc half period is shorter than STALL_LIMIT clocks, about
          313 kHz at the slowest; slower stations need a larger limit.
          strap pins are steady for at least three clocks before reset
          is released.
*/
`include "mgmt_serial_defs.vh"

module mdio_management_target (
   // clock and reset
   input  wire       clk,
   input  wire       reset,
   // address straps
   input  wire [4:0] bus_address_straps,
   // management serial pins
   input  wire       mdc,
   input  wire       mdio_in,
   output reg        mdio_out,
   output reg        mdio_oe,
   // register write observation
   output reg        reg_wr_strobe,
   output reg  [4:0] reg_wr_addr,
   output reg [15:0] reg_wr_data
);

   // states
   localparam [1:0] ST_IDLE  = 2'd0;
   localparam [1:0] ST_START = 2'd1;
   localparam [1:0] ST_FRAME = 2'd2;

   // frame fields, as told apart by the bit counter
   localparam [2:0] FLD_OP   = 3'd0;
   localparam [2:0] FLD_ADDR = 3'd1;
   localparam [2:0] FLD_REG  = 3'd2;
   localparam [2:0] FLD_TA1  = 3'd3;
   localparam [2:0] FLD_TA2  = 3'd4;
   localparam [2:0] FLD_DATA = 3'd5;

   // synchronisers
   reg        mdc_s1;
   reg        mdc_s2;
   reg        mdc_s3;
   reg        mdio_s1;
   reg        mdio_s2;
   wire [4:0] strap_sync;

   // frame state
   reg  [1:0] state;
   reg  [5:0] bit_cnt;
   reg  [1:0] opcode;
   reg  [4:0] phy_field;
   reg  [4:0] reg_field;
   reg [15:0] shift;
   reg  [4:0] own_addr;
   reg        is_read;
   reg        is_write;
   reg        drive_read;
   reg [15:0] rd_shift;
   reg        ta_bad;
   reg  [7:0] stall_cnt;

   wire        mdc_rise;
   wire        mdc_fall;
   wire [15:0] store_rd_data;
   wire        addr_match;
   wire        stalled;

   // mdc edges found from the synchronised copy only
   assign mdc_rise = mdc_s2 & ~mdc_s3;
   assign mdc_fall = ~mdc_s2 & mdc_s3;
   assign addr_match = (phy_field == own_addr);

   // opcode decode, shared by the frame check and the read/write flags
   function op_reads;
      input [1:0] op;
      begin
         op_reads = (op == `OP_READ);
      end
   endfunction

   function op_writes;
      input [1:0] op;
      begin
         op_writes = (op == `OP_WRITE);
      end
   endfunction

   // field under the bit counter, used by the read driver
   function [2:0] field_of;
      input [5:0] cnt;
      begin
         if (cnt <= `CNT_OPEND) begin
            field_of = FLD_OP;
         end else if (cnt <= `CNT_PHYEND) begin
            field_of = FLD_ADDR;
         end else if (cnt <= `CNT_REGEND) begin
            field_of = FLD_REG;
         end else if (cnt == `CNT_TA1) begin
            field_of = FLD_TA1;
         end else if (cnt == `CNT_TA2) begin
            field_of = FLD_TA2;
         end else begin
            field_of = FLD_DATA;
         end
      end
   endfunction

   // two-flop synchronisers for pins
   always @(posedge clk) begin
      if (reset) begin
         mdc_s1   <= 1'b0;
         mdc_s2   <= 1'b0;
         mdc_s3   <= 1'b0;
         mdio_s1  <= 1'b1;
         mdio_s2  <= 1'b1;
      end else begin
         mdc_s1   <= mdc;
         mdc_s2   <= mdc_s1;
         mdc_s3   <= mdc_s2;
         mdio_s1  <= mdio_in;
         mdio_s2  <= mdio_s1;
      end
   end

   // strap pins, one reset-free two-flop chain per bit, so the address
   // is still caught while reset is high
   genvar g;
   generate
      for (g = 0; g < `ADDR_W; g = g + 1) begin : g_strap
         reg s1;
         reg s2;
         always @(posedge clk) begin
            s1 <= bus_address_straps[g];
            s2 <= s1;
         end
         assign strap_sync[g] = s2;
      end
   endgenerate

   // own address follows straps during reset, then held
   always @(posedge clk) begin
      if (reset) begin
         own_addr <= strap_sync;
      end
   end

   // frame decoder, bits taken on rising mdc
   always @(posedge clk) begin
      if (reset) begin
         state         <= ST_IDLE;
         bit_cnt       <= 6'd0;
         opcode        <= 2'b00;
         phy_field     <= 5'h00;
         reg_field     <= 5'h00;
         shift         <= 16'h0000;
         is_read       <= 1'b0;
         is_write      <= 1'b0;
         ta_bad        <= 1'b0;
         reg_wr_strobe <= 1'b0;
         reg_wr_addr   <= 5'h00;
         reg_wr_data   <= 16'h0000;
      end else begin
         reg_wr_strobe <= 1'b0;
         if (stalled) begin
            // mdc stopped inside a frame: drop it, wait for a new start
            state    <= ST_IDLE;
            is_read  <= 1'b0;
            is_write <= 1'b0;
         end else if (mdc_rise) begin
            case (state)
               // wait for the zero of the start code
               ST_IDLE: begin
                  if (!mdio_s2) begin
                     state <= ST_START;
                  end
               end
               // the one completes the start code
               ST_START: begin
                  if (mdio_s2) begin
                     state   <= ST_FRAME;
                     bit_cnt <= 6'd0;
                  end
               end
               ST_FRAME: begin
                  bit_cnt <= bit_cnt + 6'd1;
                  if (bit_cnt <= `CNT_OPEND) begin
                     opcode <= {opcode[0], mdio_s2};
                  end else if (bit_cnt <= `CNT_PHYEND) begin
                     phy_field <= {phy_field[3:0], mdio_s2};
                  end else if (bit_cnt <= `CNT_REGEND) begin
                     reg_field <= {reg_field[3:0], mdio_s2};
                     if (bit_cnt == `CNT_REGEND) begin
                        is_read  <= op_reads(opcode) && addr_match;
                        is_write <= op_writes(opcode) && addr_match;
                        if (!op_reads(opcode) && !op_writes(opcode)) begin
                           state <= ST_IDLE;
                        end
                     end
                  end else if (bit_cnt == `CNT_TA1) begin
                     ta_bad <= is_write & ~mdio_s2;
                  end else if (bit_cnt == `CNT_TA2) begin
                     if (is_write && mdio_s2) begin
                        ta_bad <= 1'b1;
                     end
                  end else begin
                     shift <= {shift[14:0], mdio_s2};
                     if (bit_cnt == `CNT_DATAEND) begin
                        state <= ST_IDLE;
                        if (is_write && !ta_bad) begin
                           reg_wr_strobe <= 1'b1;
                           reg_wr_addr   <= reg_field;
                           reg_wr_data   <= {shift[14:0], mdio_s2};
                        end
                        is_read  <= 1'b0;
                        is_write <= 1'b0;
                     end
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // stall guard, counts clocks without an mdc edge inside a frame
   always @(posedge clk) begin
      if (reset) begin
         stall_cnt <= 8'h00;
      end else if (state == ST_IDLE || mdc_rise || mdc_fall) begin
         stall_cnt <= 8'h00;
      end else if (!stalled) begin
         stall_cnt <= stall_cnt + 8'h01;
      end
   end
   assign stalled = (stall_cnt == `STALL_LIMIT);

   // register store
   reg_store u_store (
      .clk     (clk),
      .reset   (reset),
      .wr_en   (reg_wr_strobe),
      .wr_addr (reg_wr_addr),
      .wr_data (reg_wr_data),
      .rd_addr (reg_field),
      .rd_data (store_rd_data)
   );

   // read driver, changes on falling mdc so bits are stable at rise
   always @(posedge clk) begin
      if (reset) begin
         mdio_out   <= 1'b1;
         mdio_oe    <= 1'b0;
         drive_read <= 1'b0;
         rd_shift   <= 16'h0000;
      end else if (state != ST_FRAME) begin
         mdio_oe    <= 1'b0;
         mdio_out   <= 1'b1;
         drive_read <= 1'b0;
      end else if (mdc_fall) begin
         if (field_of(bit_cnt) == FLD_TA2 && is_read) begin
            // first ta bit sampled; now drive zero
            mdio_oe    <= 1'b1;
            mdio_out   <= 1'b0;
            drive_read <= 1'b1;
            rd_shift   <= store_rd_data;
         end else if (drive_read && field_of(bit_cnt) == FLD_DATA) begin
            mdio_out <= rd_shift[15];
            rd_shift <= {rd_shift[14:0], 1'b0};
         end else if (!drive_read) begin
            mdio_oe <= 1'b0;
         end
      end
   end

endmodule // mdio_management_target

// [testbench/mdio_target_asserts.sv]
/* checker on the target's outputs.
 assumes: bound from tb_top; mdc half period of 4 clk or more. */
module mdio_target_asserts (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // watched pins
   input wire logic        mdc,
   input wire logic        mdio_out,
   input wire logic        mdio_oe,
   input wire logic        reg_wr_strobe,
   input wire logic [4:0]  reg_wr_addr,
   input wire logic [15:0] reg_wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       mdc_q;
   logic [5:0] rises;
   logic [7:0] still;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // mdc rises while driving, clocks since mdc moved
   always_ff @(posedge clk) begin
      mdc_q <= mdc;
      rises <= (reset || !mdio_oe) ? 6'h00 : rises + {5'h00, mdc & ~mdc_q};
      still <= (reset || mdc != mdc_q) ? 8'h00 : still + {7'h00, still != 8'hff};
   end
   chk_reset_idle: assert property ($fell(reset) |-> !mdio_oe && mdio_out)
      else $error("driving after reset");
   chk_write_pulse: assert property (reg_wr_strobe |=> !reg_wr_strobe)
      else $error("long strobe");
   chk_write_hold: assert property (!$stable({reg_wr_addr, reg_wr_data}) |-> reg_wr_strobe)
      else $error("write fields moved");
   chk_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround not zero");
   chk_read_count: assert property ($fell(mdio_oe) && still < 8'h40 |-> rises == 6'd17)
      else $error("read length wrong");
   chk_cut_release: assert property ($fell(mdio_oe) && still >= 8'h40 |-> rises < 6'd17)
      else $error("full read released late");
   chk_bit_steady: assert property (
      mdio_oe && mdc && !mdc_q |=> (!mdio_oe || $stable(mdio_out)) [*2])
      else $error("data moved at mdc rise");
   chk_stop_release: assert property (still == 8'hff |-> !mdio_oe)
      else $error("driving while mdc stands");
   chk_write_quiet: assert property (reg_wr_strobe |-> !mdio_oe)
      else $error("strobe while driving");
   cover property ($fell(mdio_oe));
   cover property (reg_wr_strobe);
   cover property (still == 8'hff);
   cover property ($fell(mdio_oe) && still >= 8'h40);
endmodule // mdio_target_asserts

// [testbench/mgmt_station.sv]
/* station model: makes mdc only within frames, drives or releases mdio.
 assumes: the bench adds the pull-up while st_oe is low. */
`include "mgmt_serial_defs.vh"
module mgmt_station (
   // pacing clock
   input wire logic clk,
   // management pins
   input wire logic mdio_line,
   output logic     mdc,
   output logic     st_oe,
   output logic     st_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle: mdc stands low, line released
   initial begin
      mdc = 1'b0;
      st_oe = 1'b0;
      st_out = 1'b1;
   end
   // 35 bits of 64 ns, set while mdc low, taken at its rise
   // stops after bit upto; upto above 0 cuts the frame with mdc left low
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, ra,
                        input logic [1:0] ta, input logic [15:0] wd, output logic [17:0] got,
                        input int upto);
      logic [34:0] bits;
      bits = {2'b11, `START_CODE, op, pa, ra, ta, wd, 1'b1};
      for (int i = 34; i >= upto; i--) begin
         st_oe = i > 0 && i < 33 && (i > 18 || op == `OP_WRITE);
         st_out = bits[i];
         repeat (4) @(negedge clk);
         mdc = 1'b1;
         if (i > 0)
            got = {got[16:0], mdio_line};
         repeat (4) @(negedge clk);
         mdc = 1'b0;
      end
   endtask
endmodule // mgmt_station

// [testbench/tb_top.sv]
/* self-checking bench for the management serial target.
 assumes: the station model makes mdc; the wire has its pull-up here. */
`include "mgmt_serial_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset, mdc, mdio_in, mdio_out, mdio_oe, st_oe, st_out, reg_wr_strobe;
   logic [4:0]  straps, own, reg_wr_addr;
   logic [15:0] reg_wr_data, wd, mem [32];
   logic [20:0] lw;
   logic [17:0] got;
   logic [7:0]  r;
   int          n_errors = 0, comparisons = 0, n_wr = 0, seed = 32'h660a;
   // pull-up wire
   assign mdio_in = (st_oe ? st_out : 1'b1) & (mdio_oe ? mdio_out : 1'b1);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   mdio_management_target uut (.clk(clk), .reset(reset), .bus_address_straps(straps),
      .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
   mgmt_station st (.clk(clk), .mdio_line(mdio_in), .mdc(mdc), .st_oe(st_oe), .st_out(st_out));
   // count write strobes
   always @(posedge clk)
      if (reg_wr_strobe === 1'b1)
         n_wr++;
   task automatic tally(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic check_rd(input logic [17:0] g, input logic [17:0] e);
      tally({14'h0000, g}, {14'h0000, e});
   endtask
   task automatic check_wr(input logic [28:0] g, input logic [28:0] e);
      tally({3'h0, g}, {3'h0, e});
   endtask
   // turnaround and data bits seen by the station
   function automatic logic [17:0] exp_read(input logic hit, input logic [15:0] d);
      return hit ? {2'b10, d} : 18'h3_ffff;
   endfunction
   // one frame, then compare line and write port
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, ra, input logic [1:0] ta,
                       input logic [15:0] d);
      int   n0;
      logic ok;
      n0 = n_wr;
      ok = op == `OP_WRITE && ta == `TA_WRITE && pa == own;
      st.frame(op, pa, ra, ta, d, got, 0);
      if (op == `OP_READ)
         check_rd(got, exp_read(pa == own, mem[ra]));
      else if (op != `OP_WRITE)
         check_rd(got, 18'h3_ffff);
      if (ok) begin
         mem[ra] = d;
         lw = {ra, d};
      end
      check_wr({8'(n_wr - n0), reg_wr_addr, reg_wr_data}, {7'h00, ok, lw});
   endtask
   task automatic test_done;
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // reset with moving straps, corner frames, random traffic
   initial begin
      reset = 1'b1;
      lw = 21'h00_0000;
      own = 5'($random(seed));
      straps = ~own;
      for (int i = 0; i < 32; i++)
         mem[i] = `REG_RESET;
      repeat (2) @(negedge clk);
      straps = own;
      repeat (4) @(negedge clk);
      reset = 1'b0;
      straps = ~own;
      xfer(`OP_WRITE, own, 5'd0, `TA_WRITE, 16'ha5a5);
      xfer(`OP_READ, own, 5'd0, `TA_WRITE, 16'hffff);
      xfer(`OP_WRITE, own, 5'd31, 2'b11, 16'hffff);
      xfer(`OP_WRITE, own, 5'd31, 2'b00, 16'hffff);
      xfer(`OP_READ, own, 5'd31, `TA_WRITE, 16'hffff);
      xfer(2'b00, own, 5'd3, 2'b11, 16'hffff);
      xfer(2'b11, own, 5'd3, 2'b11, 16'hffff);
      st.frame(`OP_READ, own, 5'd0, `TA_WRITE, 16'hffff, got, 9);
      repeat (300) @(negedge clk);
      check_rd({17'h0_0000, mdio_oe}, 18'h0_0000);
      xfer(`OP_READ, own, 5'd0, `TA_WRITE, 16'hffff);
      for (int i = 0; i < 40; i++) begin
         r = 8'($random(seed));
         wd = 16'($random(seed));
         xfer(r[5] ? `OP_READ : `OP_WRITE, r[7:6] == 2'b00 ? own + 5'd1 + {1'b0, wd[3:0]} : own,
              r[4:0], `TA_WRITE, wd);
      end
      test_done;
   end
   // watchdog
   initial begin
      #400000;
      n_errors++;
      test_done;
   end
endmodule // tb_top
bind mdio_management_target mdio_target_asserts chk (.clk(clk), .reset(reset), .mdc(mdc),
   .mdio_out(mdio_out), .mdio_oe(mdio_oe), .reg_wr_strobe(reg_wr_strobe),
   .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
